// file: design/sxm_pkg.sv
`default_nettype none
package sxm_pkg;
   // frame characters
   localparam logic [7:0]  SOF_BYTE      = 8'h1B;  // start of every frame
   localparam logic [7:0]  CMD_BYTE      = 8'h58;  // request command byte
   localparam logic [7:0]  BUF_BYTE      = 8'h54;  // data buffer message type
   localparam logic [7:0]  EOB_BYTE      = 8'h17;  // end of block, opens trailer
   localparam logic [7:0]  BCAST_ID      = 8'hFF;  // broadcast station identifier byte
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;  // unused bytes
   localparam logic [7:0]  WR_CODE       = 8'h02;  // write request code
   localparam logic [7:0]  RD_CODE       = 8'h01;  // read request code
   localparam logic [7:0]  ATT_CODE      = 8'h00;  // attach request code
   localparam logic [7:0]  SEG_BIT_OUT   = 8'h48;  // output table, bit mode
   localparam logic [7:0]  SEG_WORD_REG  = 8'h08;  // register table, word mode
   // byte positions, counted from 1
   localparam logic [16:0] POS_SOF       = 17'h00001;
   localparam logic [16:0] POS_CMD       = 17'h00002;
   localparam logic [16:0] POS_ID_LO     = 17'h00003;
   localparam logic [16:0] POS_ID_HI     = 17'h0000A;
   localparam logic [16:0] POS_CODE      = 17'h0000B;
   localparam logic [16:0] POS_SEG       = 17'h0000C;
   localparam logic [16:0] POS_OFS_LO    = 17'h0000D;
   localparam logic [16:0] POS_OFS_HI    = 17'h0000E;
   localparam logic [16:0] POS_LEN_LO    = 17'h0000F;
   localparam logic [16:0] POS_LEN_HI    = 17'h00010;
   localparam logic [16:0] POS_DAT_LO    = 17'h00011;
   localparam logic [16:0] POS_DAT_HI    = 17'h00012;
   localparam logic [16:0] POS_EOB       = 17'h00013;
   localparam logic [16:0] POS_NXT_TYPE  = 17'h00014;
   localparam logic [16:0] POS_NXT_LO    = 17'h00015;
   localparam logic [16:0] POS_NXT_HI    = 17'h00016;
   localparam logic [16:0] REQ_LEN       = 17'h00018;  // request frame is 24 bytes
   localparam logic [16:0] BUF_OVERHEAD  = 17'h00008;  // sof, type, eob, 4 zeros, check
   localparam logic [16:0] BUF_DAT_FIRST = 17'h00003;
   localparam logic [15:0] SHORT_MAX     = 16'h0002;   // largest write without buffer
   // timing
   localparam int          CLK_MHZ       = 10;
   localparam int          RESP_TMO_US   = 1000;
   localparam int          BCAST_DLY_US  = 400;
   localparam int          RESP_TMO_CYC  = RESP_TMO_US * CLK_MHZ;
   localparam logic [15:0] BCAST_DLY_CYC = 16'(BCAST_DLY_US * CLK_MHZ);
   localparam int          FIFO_DEPTH    = 16;
   localparam int          FIFO_WIDTH    = 8;
   // user commands
   typedef enum logic [1:0] {SXM_OP_ATTACH = 2'h0, SXM_OP_READ = 2'h1,
                             SXM_OP_WRITE = 2'h2} sxm_op_t;
   // received reply kinds
   typedef enum logic [1:0] {SXM_RX_ATT = 2'h0, SXM_RX_INTER = 2'h1,
                             SXM_RX_FINAL = 2'h2} sxm_rx_t;
   // frame kinds
   typedef enum logic [1:0] {SXM_FR_ATT = 2'h0, SXM_FR_REQ = 2'h1,
                             SXM_FR_BUF = 2'h2} sxm_fr_t;
   // session states, gray along idle-attach-open-inter-final
   typedef enum logic [2:0] {SXM_IDLE = 3'h0, SXM_WAIT_ATT = 3'h1, SXM_OPEN = 3'h3,
                             SXM_WAIT_INT = 3'h2, SXM_WAIT_FIN = 3'h6} sxm_st_t;
endpackage
`default_nettype wire

// file: design/sxm_master.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// write data fifo: stalls the buffer frame when empty, back-pressures the user
module sxm_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_resetn,
   input  wire logic [W-1:0] i_in_data,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   output logic [W-1:0]      o_out_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;   // storage
      logic [AW-1:0]       wp;    // write index
      logic [AW-1:0]       rp;    // read index
      logic [AW:0]         cnt;   // fill level
      logic                rdy;   // registered so the ready port is a flop
   } sxm_fifo_s_t;
   sxm_fifo_s_t s_q, s_d;
   logic push, pop;
   // push and pop bookkeeping
   always_comb begin
      s_d  = s_q;
      push = i_in_valid && s_q.rdy;
      pop  = i_out_ready && (s_q.cnt != '0);
      if (push) begin
         s_d.mem[s_q.wp] = i_in_data;
         s_d.wp          = AW'(s_q.wp + 1'b1);
      end
      if (pop) begin
         s_d.rp = AW'(s_q.rp + 1'b1);
      end
      s_d.cnt  = (AW+1)'(s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      s_d.rdy  = (s_d.cnt != (AW+1)'(D));  // room left after this edge
      if (!i_resetn) begin
         s_d = '0;
      end
   end
   // state register
   always_ff @(posedge i_core_clk) begin
      s_q <= s_d;
   end
   assign o_in_ready  = s_q.rdy;
   assign o_out_valid = (s_q.cnt != '0);
   assign o_out_data  = s_q.mem[s_q.rp];
endmodule
////////////////////////////////////////////////////////////////////////////////
// session master: builds frames and walks the five-state session machine
module sxm_master
   import sxm_pkg::*;
#(
   parameter logic [15:0] RESP_CYC = 16'(RESP_TMO_CYC)  // response timeout, cycles
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_cmd_valid,     // one-cycle user command
   input  wire sxm_pkg::sxm_op_t i_cmd_op,
   input  wire logic        i_cmd_bcast,
   input  wire logic [63:0] i_station_identifier,
   input  wire logic        i_cmd_word_mode, // 1: register words, 0: output bits
   input  wire logic [15:0] i_cmd_offset,
   input  wire logic [15:0] i_cmd_length,
   input  wire logic [15:0] i_cmd_nbytes,    // write data byte count
   input  wire logic [15:0] i_cmd_short_data,
   input  wire logic [7:0]  i_wr_data,
   input  wire logic        i_wr_valid,
   output logic             o_wr_ready,
   output logic [7:0]       o_tx_data,
   output logic             o_tx_valid,
   input  wire logic        i_tx_ready,
   input  wire logic        i_rx_valid,      // one-cycle received reply
   input  wire sxm_pkg::sxm_rx_t i_rx_kind,
   input  wire logic        i_rx_check_ok,
   input  wire logic        i_rx_fatal,
   input  wire logic        i_rx_error,
   output logic             o_cmd_done,
   output logic             o_cmd_error,
   output logic             o_abort,
   output sxm_pkg::sxm_st_t o_state
);
   import sxm_pkg::*;
   typedef struct packed {
      sxm_st_t     st;      // session state
      logic        tx_act;  // frame being sent
      sxm_fr_t     fr;      // kind of frame
      logic [16:0] pos;     // byte position of o_tx_data
      logic [7:0]  chk;     // running check over accepted bytes
      logic [7:0]  dat;     // byte on the line
      logic        vld;     // byte valid
      logic        tmr_run; // a wait timer runs
      logic        tmr_bc;  // it is the broadcast delay
      logic [15:0] tmr;     // cycles left
      sxm_op_t     op;      // latched command
      logic        bc;
      logic        wm;
      logic [15:0] ofs, len, nb, sd;
      logic        done, err, abrt;
   } sxm_s_t;
   sxm_s_t s_q, s_d;
   logic [7:0] f_data;
   logic       f_valid, f_pop, acc, last, expired, rx_good;
   logic [16:0] flen, np;
   logic [7:0]  chk_n, b;
   // check byte step; the code accumulates every byte ahead of the check byte
   function automatic logic [7:0] chk_step(input logic [7:0] c, input logic [7:0] d);
      return {c[6:0], c[7]} ^ d;
   endfunction
   // a write longer than one word needs a data buffer frame
   function automatic logic needs_buf(input sxm_op_t op, input logic [15:0] nb);
      return (op == SXM_OP_WRITE) && (nb > SHORT_MAX);
   endfunction
   sxm_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .i_in_data  (i_wr_data),
      .i_in_valid (i_wr_valid),
      .o_in_ready (o_wr_ready),
      .o_out_data (f_data),
      .o_out_valid(f_valid),
      .i_out_ready(f_pop)
   );
   ////////////////////////////////////////////////////////////////////////////
   // frame builder, session machine and timers
   always_comb begin
      s_d       = s_q;
      s_d.done  = 1'b0;
      s_d.err   = 1'b0;
      s_d.abrt  = 1'b0;
      f_pop     = 1'b0;
      b         = ZERO_BYTE;
      flen      = (s_q.fr == SXM_FR_BUF) ? 17'(s_q.nb + BUF_OVERHEAD) : REQ_LEN;
      acc       = s_q.vld && i_tx_ready;
      last      = acc && (s_q.pos == flen);
      chk_n     = acc ? chk_step(s_q.chk, s_q.dat) : s_q.chk;
      np        = acc ? 17'(s_q.pos + 1'b1) : s_q.pos;
      expired   = s_q.tmr_run && (s_q.tmr == 16'h0000);
      rx_good   = i_rx_check_ok && !i_rx_fatal;
      s_d.chk   = chk_n;
      // byte at the next position
      if (np == flen) begin
         b = chk_n;
      end else if (np == POS_SOF) begin
         b = SOF_BYTE;
      end else if (s_q.fr == SXM_FR_BUF) begin
         if (np == POS_CMD) begin
            b = BUF_BYTE;
         end else if (np < 17'(s_q.nb + BUF_DAT_FIRST)) begin
            b = f_data;
         end else if (np == 17'(s_q.nb + BUF_DAT_FIRST)) begin
            b = EOB_BYTE;
         end
      end else begin
         case (np)
            POS_CMD:      b = CMD_BYTE;
            POS_CODE:     b = (s_q.fr == SXM_FR_ATT) ? ATT_CODE :
                              (s_q.op == SXM_OP_WRITE) ? WR_CODE : RD_CODE;
            POS_SEG:      b = s_q.wm ? SEG_WORD_REG : SEG_BIT_OUT;
            POS_OFS_LO:   b = s_q.ofs[7:0];
            POS_OFS_HI:   b = s_q.ofs[15:8];
            POS_LEN_LO:   b = s_q.len[7:0];
            POS_LEN_HI:   b = s_q.len[15:8];
            POS_DAT_LO:   b = needs_buf(s_q.op, s_q.nb) ? ZERO_BYTE : s_q.sd[7:0];
            POS_DAT_HI:   b = needs_buf(s_q.op, s_q.nb) ? ZERO_BYTE : s_q.sd[15:8];
            POS_EOB:      b = EOB_BYTE;
            POS_NXT_TYPE: b = needs_buf(s_q.op, s_q.nb) ? BUF_BYTE : ZERO_BYTE;
            POS_NXT_LO:   b = needs_buf(s_q.op, s_q.nb) ?
                              8'(s_q.nb + BUF_OVERHEAD) : ZERO_BYTE;
            POS_NXT_HI:   b = needs_buf(s_q.op, s_q.nb) ?
                              8'((s_q.nb + BUF_OVERHEAD) >> 8) : ZERO_BYTE;
            default: begin
               if (np >= POS_ID_LO && np <= POS_ID_HI) begin
                  b = s_q.bc ? BCAST_ID :
                      8'(i_station_identifier >> {np[2:0] - 3'h3, 3'h0});
               end
            end
         endcase
      end
      // byte transmitter; a buffer data byte waits for the fifo
      if (last) begin
         s_d.tx_act  = 1'b0;
         s_d.vld     = 1'b0;
         s_d.tmr_run = 1'b1;
         s_d.tmr_bc  = s_q.bc;
         s_d.tmr     = s_q.bc ? 16'(BCAST_DLY_CYC - 1'b1) : 16'(RESP_CYC - 1'b1);
      end else if (s_q.tx_act && (!s_q.vld || acc)) begin
         s_d.pos = np;
         s_d.dat = b;
         if (s_q.fr == SXM_FR_BUF && np >= BUF_DAT_FIRST &&
             np < 17'(s_q.nb + BUF_DAT_FIRST)) begin
            s_d.vld = f_valid;
            f_pop   = f_valid;
         end else begin
            s_d.vld = 1'b1;
         end
      end
      if (s_q.tmr_run && !expired) begin
         s_d.tmr = 16'(s_q.tmr - 1'b1);
      end
      // session events; anything outside the table aborts
      if (i_cmd_valid) begin
         s_d.op  = i_cmd_op;
         s_d.bc  = i_cmd_bcast;
         s_d.wm  = i_cmd_word_mode;
         s_d.ofs = i_cmd_offset;
         s_d.len = i_cmd_length;
         s_d.nb  = i_cmd_nbytes;
         s_d.sd  = i_cmd_short_data;
         s_d.pos = POS_SOF;
         s_d.chk = 8'h00;
         s_d.vld = 1'b0;
         s_d.tx_act  = 1'b1;
         s_d.tmr_run = 1'b0;
         if (s_q.st == SXM_IDLE && i_cmd_op == SXM_OP_ATTACH) begin
            s_d.fr = SXM_FR_ATT;
            s_d.st = SXM_WAIT_ATT;
         end else if (s_q.st == SXM_OPEN && !s_q.tx_act && i_cmd_op != SXM_OP_ATTACH) begin
            s_d.fr = SXM_FR_REQ;
            s_d.st = needs_buf(i_cmd_op, i_cmd_nbytes) ? SXM_WAIT_INT : SXM_WAIT_FIN;
         end else begin
            s_d.st     = SXM_IDLE;
            s_d.tx_act = 1'b0;
            s_d.abrt   = 1'b1;
         end
      end else if (i_rx_valid) begin
         s_d.tmr_run = 1'b0;
         case (s_q.st)
            SXM_WAIT_ATT: begin
               s_d.st = (i_rx_kind == SXM_RX_ATT && rx_good) ? SXM_OPEN : SXM_IDLE;
            end
            SXM_WAIT_INT: begin
               if (i_rx_kind == SXM_RX_INTER && rx_good) begin
                  s_d.fr     = SXM_FR_BUF;
                  s_d.pos    = POS_SOF;
                  s_d.chk    = 8'h00;
                  s_d.vld    = 1'b0;
                  s_d.tx_act = 1'b1;
                  s_d.st     = SXM_WAIT_FIN;
               end else begin
                  s_d.st = (i_rx_kind == SXM_RX_FINAL && rx_good) ? SXM_OPEN : SXM_IDLE;
               end
            end
            SXM_WAIT_FIN: begin
               s_d.st = (i_rx_kind == SXM_RX_FINAL && rx_good) ? SXM_OPEN : SXM_IDLE;
            end
            default: s_d.st = SXM_IDLE;
         endcase
         // a reply to a broadcast, or during sending, is out of the table
         if (s_q.bc || s_q.tx_act) begin
            s_d.st = SXM_IDLE;
         end
         s_d.done = (s_d.st == SXM_OPEN);
         s_d.err  = (s_d.st == SXM_OPEN) && i_rx_error;
         s_d.abrt = (s_d.st == SXM_IDLE);
         if (s_d.st == SXM_IDLE) begin
            s_d.tx_act = 1'b0;
            s_d.vld    = 1'b0;
         end
      end else if (expired) begin
         s_d.tmr_run = 1'b0;
         if (!s_q.tmr_bc) begin
            s_d.st   = SXM_IDLE;
            s_d.abrt = 1'b1;
         end else if (s_q.st == SXM_WAIT_INT) begin
            s_d.fr     = SXM_FR_BUF;
            s_d.pos    = POS_SOF;
            s_d.chk    = 8'h00;
            s_d.tx_act = 1'b1;
            s_d.st     = SXM_WAIT_FIN;
         end else begin
            s_d.st   = SXM_OPEN;
            s_d.done = 1'b1;
         end
      end
      if (!i_resetn) begin
         s_d    = '0;
         s_d.st = SXM_IDLE;
      end
   end
   // state register
   always_ff @(posedge i_core_clk) begin
      s_q <= s_d;
   end
   assign o_tx_data   = s_q.dat;
   assign o_tx_valid  = s_q.vld;
   assign o_cmd_done  = s_q.done;
   assign o_cmd_error = s_q.err;
   assign o_abort     = s_q.abrt;
   assign o_state     = s_q.st;
   ////////////////////////////////////////////////////////////////////////////
   // checks on the produced frames and the session machine
   sequence seq_idle_attach;
      s_q.st == SXM_IDLE && i_cmd_valid && i_cmd_op == SXM_OP_ATTACH;
   endsequence
   sequence seq_wait_bcast_reply;
      s_q.st != SXM_IDLE && s_q.st != SXM_OPEN && s_q.bc && i_rx_valid && !i_cmd_valid;
   endsequence
   a_frame_start: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_tx_valid && s_q.pos == POS_SOF |-> o_tx_data == SOF_BYTE)
      else $error("frame does not open with start byte");
   a_req_cmd_byte: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_tx_valid && s_q.pos == POS_CMD && s_q.fr != SXM_FR_BUF |-> o_tx_data == CMD_BYTE)
      else $error("request byte two wrong");
   a_bcast_id: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_tx_valid && s_q.bc && s_q.fr != SXM_FR_BUF && s_q.pos >= POS_ID_LO &&
      s_q.pos <= POS_ID_HI |-> o_tx_data == BCAST_ID)
      else $error("broadcast identifier not all ones");
   a_write_code: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_tx_valid && s_q.fr == SXM_FR_REQ && s_q.op == SXM_OP_WRITE && s_q.pos == POS_CODE
      |-> o_tx_data == WR_CODE)
      else $error("write code wrong");
   a_end_block: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_tx_valid && s_q.fr != SXM_FR_BUF && s_q.pos == POS_EOB |-> o_tx_data == EOB_BYTE)
      else $error("end of block misplaced");
   a_check_last: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_tx_valid && s_q.pos == flen |-> o_tx_data == s_q.chk)
      else $error("check byte wrong");
   // attach frame opens two edges after the take, the first byte needs no fifo
   sequence seq_attach_start;
      s_q.st == SXM_WAIT_ATT && s_q.tx_act ##1 (o_tx_valid && o_tx_data == SOF_BYTE);
   endsequence
   a_attach_step: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      seq_idle_attach |=> seq_attach_start)
      else $error("attach not sent from idle");
   a_bcast_noreply: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      seq_wait_bcast_reply |=> o_state == SXM_IDLE && o_abort)
      else $error("reply to broadcast accepted");
   a_resp_timeout: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      expired && !s_q.tmr_bc && !i_cmd_valid && !i_rx_valid |=> o_state == SXM_IDLE && o_abort)
      else $error("timeout did not abort");
endmodule
`default_nettype wire

// file: tb/sxm_slave_model.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// slave stand-in: collects frames, answers directed ones after a short pause
module sxm_slave_model
   import sxm_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_resetn,
   input  wire logic [7:0]  i_tx_data,
   input  wire logic        i_tx_valid,
   input  wire logic        i_slow,        // accept a byte only every other cycle
   input  wire logic        i_mute,        // never answer, provokes a timeout
   input  wire logic        i_bad,         // reply with a failing check byte
   output logic             o_tx_ready,
   output logic             o_rx_valid,
   output sxm_pkg::sxm_rx_t o_rx_kind,
   output logic             o_rx_check_ok,
   output logic             o_rx_fatal,
   output logic             o_rx_error
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  fr [0:63];                 // bytes of the frame in flight
   logic [15:0] blen;                      // buffer length announced by the request
   logic        bc;                        // last request was broadcast
   int          n, flen, dly;              // byte count, frame length, reply pause
   // check byte is judged upstream; the bench can force a mismatch
   assign o_rx_check_ok = !i_bad;
   assign o_rx_fatal    = 1'b0;
   assign o_rx_error    = 1'b0;
   ////////////////////////////////////////////////////////////////////////////////
   // frames open with 1B; a buffer frame is as long as the request announced
   always @(posedge i_core_clk) begin
      o_rx_valid <= 1'b0;
      o_tx_ready <= !i_slow || !o_tx_ready;
      if (!i_resetn) begin
         n = 0;
         dly = 0;
         bc = 1'b0;
      end else begin
         if (i_tx_valid && o_tx_ready) begin
            fr[n] = i_tx_data;
            n = n + 1;
            flen = (n > 1 && fr[1] == BUF_BYTE) ? 32'(blen) : 24;
            if (n == flen) begin
               if (fr[1] == CMD_BYTE) begin
                  bc = (fr[2] == BCAST_ID);
                  blen = {fr[21], fr[20]};
                  o_rx_kind <= (fr[10] == ATT_CODE) ? SXM_RX_ATT :
                     (fr[19] == BUF_BYTE) ? SXM_RX_INTER : SXM_RX_FINAL;
               end else begin
                  o_rx_kind <= SXM_RX_FINAL;
               end
               n = 0;
               // a broadcast is never answered
               if (!bc && !i_mute) dly = 3;
            end
         end
         if (dly > 0) begin
            dly = dly - 1;
            if (dly == 0) o_rx_valid <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/sxm_master_tb.sv
`default_nettype none
module sxm_master_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import sxm_pkg::*;
   logic        i_core_clk = 0, i_resetn = 0, i_cmd_valid = 0, i_cmd_bcast = 0;
   logic        i_cmd_word_mode = 0, i_wr_valid = 0, slow = 0, mute = 0, bad = 0;
   sxm_op_t     i_cmd_op = SXM_OP_ATTACH;
   logic [15:0] i_cmd_offset = 0, i_cmd_length = 0, i_cmd_nbytes = 0, i_cmd_short_data = 0;
   logic [7:0]  i_wr_data = 0, o_tx_data;
   logic        o_wr_ready, o_tx_valid, tx_ready, rx_valid, ck_ok, fatal, rerr;
   logic        o_cmd_done, o_cmd_error, o_abort;
   sxm_rx_t     rx_kind;
   sxm_st_t     o_state;
   logic [63:0] sid = 64'h0807060504030201;  // arbitrary station identifier
   logic [7:0]  txq [$], ex [$];             // bytes seen on the line, bytes expected
   int          errors = 0, n_compared = 0, nc;
   always #50 i_core_clk = !i_core_clk;
   sxm_master #(.RESP_CYC(16'h0014)) i_sxm_master (.i_core_clk, .i_resetn, .i_cmd_valid,
      .i_cmd_op, .i_cmd_bcast, .i_station_identifier(sid), .i_cmd_word_mode, .i_cmd_offset,
      .i_cmd_length, .i_cmd_nbytes, .i_cmd_short_data, .i_wr_data, .i_wr_valid, .o_wr_ready,
      .o_tx_data, .o_tx_valid, .i_tx_ready(tx_ready), .i_rx_valid(rx_valid),
      .i_rx_kind(rx_kind), .i_rx_check_ok(ck_ok), .i_rx_fatal(fatal), .i_rx_error(rerr),
      .o_cmd_done, .o_cmd_error, .o_abort, .o_state);
   sxm_slave_model i_sxm_slave_model (.i_core_clk, .i_resetn, .i_tx_data(o_tx_data),
      .i_tx_valid(o_tx_valid), .i_slow(slow), .i_mute(mute), .i_bad(bad), .o_tx_ready(tx_ready),
      .o_rx_valid(rx_valid), .o_rx_kind(rx_kind), .o_rx_check_ok(ck_ok),
      .o_rx_fatal(fatal), .o_rx_error(rerr));
   // every accepted byte is queued for comparison
   always @(posedge i_core_clk) if (o_tx_valid && tx_ready) txq.push_back(o_tx_data);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("errors=%0d compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // expected check byte: rotate left then xor, over all bytes before it
   task automatic chk_frame();
      logic [7:0] c;
      int t;
      c = 8'h00;
      t = 0;
      foreach (ex[i]) c = {c[6:0], c[7]} ^ ex[i];
      ex.push_back(c);
      while (txq.size() < ex.size() && t < 3000) begin
         @(posedge i_core_clk);
         t++;
      end
      #1;
      foreach (ex[i]) chk(txq.size() > 0 ? txq.pop_front() : 8'hXX, ex[i]);
   endtask
   task automatic mk_req(input logic [7:0] code, seg, input logic [15:0] ofs, len, dat,
                         input logic [7:0] nt, input logic [15:0] bl, input logic bc);
      ex = {SOF_BYTE, CMD_BYTE};
      for (int i = 0; i < 8; i++) ex.push_back(bc ? BCAST_ID : sid[8*i+:8]);
      ex = {ex, code, seg, ofs[7:0], ofs[15:8], len[7:0], len[15:8], dat[7:0], dat[15:8],
            EOB_BYTE, nt, bl[7:0], bl[15:8], ZERO_BYTE};
   endtask
   task automatic cmd(input sxm_op_t op, input logic bc, wm, input logic [15:0] ofs, len,
                      nb, sd, input sxm_st_t st);
      @(posedge i_core_clk);
      i_cmd_valid     <= 1'b1;
      i_cmd_op        <= op;
      i_cmd_bcast     <= bc;
      i_cmd_word_mode <= wm;
      {i_cmd_offset, i_cmd_length, i_cmd_nbytes, i_cmd_short_data} <= {ofs, len, nb, sd};
      @(posedge i_core_clk);
      i_cmd_valid <= 1'b0;
      #1;
      chk(o_state, st);
   endtask
   // waits for a done (ab=0) or abort (ab=1) pulse, then checks the state it left;
   // the pulse stands one cycle only, so it is looked at before the first wait
   task automatic wait_ev(input logic ab, input int lim, input sxm_st_t st);
      nc = 0;
      while ((ab ? o_abort : o_cmd_done) !== 1'b1 && nc < lim) begin
         @(posedge i_core_clk);
         #1;
         nc++;
      end
      chk(nc < lim, 1);
      chk(o_state, st);
      if (!ab) chk(o_cmd_error, 0);
   endtask
   task automatic push(input int first, input int cnt);
      @(posedge i_core_clk);
      for (int k = first; k < first + cnt; k++) begin
         i_wr_data <= 8'(8'h31 + k);
         i_wr_valid <= 1'b1;
         do @(posedge i_core_clk); while (o_wr_ready !== 1'b1);
      end
      i_wr_valid <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // long write: fifo filled until refused, slow line, buffer frame follows
   task automatic t_long();
      slow <= 1'b1;
      push(0, 16);
      @(posedge i_core_clk);
      #1;
      chk(o_wr_ready, 0);
      cmd(SXM_OP_WRITE, 0, 0, 16'h0012, 16'h00A0, 16'h0014, 16'h0000, SXM_WAIT_INT);
      fork
         push(16, 4);
         begin
            mk_req(WR_CODE, SEG_BIT_OUT, 16'h0012, 16'h00A0, 16'h0, BUF_BYTE, 16'h001C, 0);
            chk_frame();
            ex = {SOF_BYTE, BUF_BYTE};
            for (int k = 0; k < 20; k++) ex.push_back(8'(8'h31 + k));
            ex = {ex, EOB_BYTE, ZERO_BYTE, ZERO_BYTE, ZERO_BYTE, ZERO_BYTE};
            chk_frame();
            wait_ev(0, 200, SXM_OPEN);
         end
      join
      slow <= 1'b0;
   endtask
   initial begin
      #3000000;
      errors++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      @(posedge i_core_clk);
      #1;
      chk(o_state, SXM_IDLE);
      chk(o_wr_ready, 1);
      cmd(SXM_OP_WRITE, 0, 0, 0, 0, 0, 0, SXM_IDLE);
      wait_ev(1, 3, SXM_IDLE);
      cmd(SXM_OP_ATTACH, 0, 0, 0, 0, 0, 0, SXM_WAIT_ATT);
      mk_req(ATT_CODE, SEG_BIT_OUT, 0, 0, 0, 0, 0, 0);
      chk_frame();
      wait_ev(0, 100, SXM_OPEN);
      cmd(SXM_OP_WRITE, 0, 1, 16'h0063, 16'h0001, 16'h0002, 16'h0004, SXM_WAIT_FIN);
      mk_req(WR_CODE, SEG_WORD_REG, 16'h0063, 16'h0001, 16'h0004, 0, 0, 0);
      chk_frame();
      wait_ev(0, 100, SXM_OPEN);
      t_long();
      cmd(SXM_OP_WRITE, 1, 0, 16'h0012, 16'h0001, 16'h0002, 16'h0004, SXM_WAIT_FIN);
      mk_req(WR_CODE, SEG_BIT_OUT, 16'h0012, 16'h0001, 16'h0004, 0, 0, 1);
      chk_frame();
      wait_ev(0, 4100, SXM_OPEN);
      chk(nc > 3990, 1);
      mute <= 1'b1;
      cmd(SXM_OP_READ, 0, 1, 16'h0005, 16'h0002, 0, 0, SXM_WAIT_FIN);
      mk_req(RD_CODE, SEG_WORD_REG, 16'h0005, 16'h0002, 0, 0, 0, 0);
      chk_frame();
      wait_ev(1, 30, SXM_IDLE);
      // attach answered with a failing check byte: abort long before the timeout
      mute <= 1'b0;
      bad <= 1'b1;
      cmd(SXM_OP_ATTACH, 0, 0, 0, 0, 0, 0, SXM_WAIT_ATT);
      mk_req(ATT_CODE, SEG_BIT_OUT, 0, 0, 0, 0, 0, 0);
      chk_frame();
      wait_ev(1, 30, SXM_IDLE);
      chk(nc < 8, 1);
      close_out();
   end
endmodule
`default_nettype wire
